// ### src/board_status_pkg.sv
// constants for the board led and reset status block
package board_status_pkg;
  localparam logic [15:0] led_port_addr    = 16'h0456;
  localparam logic [15:0] reset_port_addr  = 16'h0457;
  localparam int          led_manual_bit   = 3;
  localparam int          led_red_bit      = 2;
  localparam int          led_green_bit    = 1;
  localparam int          led_blue_bit     = 0;
  localparam logic [7:0]  led_ctrl_reset   = 8'h00;
  localparam logic [7:0]  led_ctrl_mask    = 8'h0f;
  localparam int          rst_main_bit     = 7;
  localparam int          rst_core_bit     = 6;
  localparam int          rst_nonstby_bit  = 5;
  localparam int          rst_mem_bit      = 4;
  localparam int          rst_stby_bit     = 3;
  localparam int          rst_pci33_bit    = 2;
  localparam int          rst_pcirst_bit   = 1;
  localparam int          rst_button_bit   = 0;
  // a source also marks every higher priority number; equal numbers stay apart
  localparam logic [7:0]  prio4_mask       = 8'h02;
  localparam logic [7:0]  prio3_mask       = 8'h02;
  localparam logic [7:0]  prio2_mask       = 8'hf2;
  localparam logic [7:0]  prio1_mask       = 8'hfa;
  localparam logic [7:0]  flags_reset      = 8'h00;
  // blink half period for network activity, in cycles of the 200 mhz clock
  localparam int          blink_ms         = 50;
  localparam int          clk_mhz          = 200;
  localparam int          blink_cycles     = blink_ms * clk_mhz * 1000;
endpackage

// ### src/status_led_mux.sv
// automatic status colour selection for the tri-colour led
`timescale 1ns/10ps
module status_led_mux (
  input  wire logic       i_in_reset,
  input  wire logic       i_standby,
  input  wire logic       i_thermal_near,
  input  wire logic       i_disk_active,
  input  wire logic       i_link_10,
  input  wire logic       i_link_100,
  input  wire logic       i_blink_phase,
  input  wire logic       i_net_active,
  output logic [2:0]      o_rgb
);
  // priority: reset, standby, thermal, disk, link, normal
  always_comb begin
    if (i_in_reset) begin
      o_rgb = 3'h4;
    end else if (i_standby) begin
      o_rgb = 3'h6;
    end else if (i_thermal_near) begin
      o_rgb = 3'h7;
    end else if (i_disk_active) begin
      o_rgb = 3'h1;
    end else if (i_link_100) begin
      o_rgb = 3'h5;
    end else if (i_link_10) begin
      o_rgb = 3'h3;
    end else begin
      o_rgb = 3'h2;
    end
    if (i_net_active && !i_blink_phase) begin
      o_rgb = 3'h0;
    end
  end
endmodule // status_led_mux

// ### src/board_led_and_reset_status.sv
// led control and reset cause registers on the byte i/o port bus
`timescale 1ns/10ps
module board_led_and_reset_status (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_flags_por_n,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic        i_evt_main_power,
  input  wire logic        i_evt_core_power,
  input  wire logic        i_evt_nonstby_power,
  input  wire logic        i_evt_mem_power,
  input  wire logic        i_evt_stby_power,
  input  wire logic        i_evt_pci33,
  input  wire logic        i_evt_pci_reset,
  input  wire logic        i_evt_button,
  input  wire logic        i_button_is_reset,
  input  wire logic        i_in_reset,
  input  wire logic        i_standby,
  input  wire logic        i_thermal_near,
  input  wire logic        i_disk_active,
  input  wire logic        i_link_10,
  input  wire logic        i_link_100,
  input  wire logic        i_net_active,
  output logic [7:0]       o_io_rdata,
  output logic             o_io_rvalid,
  output logic             o_led_red,
  output logic             o_led_green,
  output logic             o_led_blue
);

  ////////////////////////////////////////////////////////////////////////////
  // led control register

  logic [7:0] led_ctrl;
  logic       led_wr;
  logic       rst_rd;
  logic       rst_wr;

  assign led_wr = i_io_wr && (i_io_addr == board_status_pkg::led_port_addr);
  assign rst_wr = i_io_wr && (i_io_addr == board_status_pkg::reset_port_addr);
  assign rst_rd = i_io_rd && (i_io_addr == board_status_pkg::reset_port_addr);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      led_ctrl <= board_status_pkg::led_ctrl_reset;
    end else if (led_wr) begin
      // reserved high bits are dropped; zero returns to automatic
      led_ctrl <= i_io_wdata & board_status_pkg::led_ctrl_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink divider for network activity

  logic [31:0] blink_cnt;
  logic        blink_phase;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b1;
    end else if (blink_cnt == 32'(board_status_pkg::blink_cycles - 1)) begin
      blink_cnt   <= 32'h0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // colour selection

  logic [2:0] auto_rgb;
  logic [2:0] next_rgb;

  status_led_mux u_auto (
    .i_in_reset     (i_in_reset),
    .i_standby      (i_standby),
    .i_thermal_near (i_thermal_near),
    .i_disk_active  (i_disk_active),
    .i_link_10      (i_link_10),
    .i_link_100     (i_link_100),
    .i_blink_phase  (blink_phase),
    .i_net_active   (i_net_active),
    .o_rgb          (auto_rgb)
  );

  always_comb begin
    if (led_ctrl[board_status_pkg::led_manual_bit]) begin
      next_rgb = {led_ctrl[board_status_pkg::led_red_bit],
                  led_ctrl[board_status_pkg::led_green_bit],
                  led_ctrl[board_status_pkg::led_blue_bit]};
    end else begin
      // values without bit 3 but nonzero are treated as automatic too
      next_rgb = auto_rgb;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_led_red   <= 1'b0;
      o_led_green <= 1'b0;
      o_led_blue  <= 1'b0;
    end else begin
      o_led_red   <= next_rgb[2];
      o_led_green <= next_rgb[1];
      o_led_blue  <= next_rgb[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags

  logic [7:0] flags;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  always_comb begin
    set_vec = 8'h00;
    if (i_evt_stby_power) begin
      set_vec = set_vec | board_status_pkg::prio1_mask;
    end
    if (i_evt_main_power) begin
      set_vec = set_vec | board_status_pkg::prio2_mask;
    end
    if (i_evt_core_power || i_evt_nonstby_power || i_evt_mem_power) begin
      set_vec = set_vec | board_status_pkg::prio3_mask;
    end
    set_vec[board_status_pkg::rst_core_bit]    |= i_evt_core_power;
    set_vec[board_status_pkg::rst_nonstby_bit] |= i_evt_nonstby_power;
    set_vec[board_status_pkg::rst_mem_bit]     |= i_evt_mem_power;
    set_vec[board_status_pkg::rst_pcirst_bit]  |= i_evt_pci_reset;
    set_vec[board_status_pkg::rst_pci33_bit]   |= i_evt_pci33;
    // a button set up for another function never records a reset
    set_vec[board_status_pkg::rst_button_bit]  |= i_evt_button && i_button_is_reset;
  end

  assign clr_vec = rst_wr ? i_io_wdata : 8'h00;

  // own power-on reset only: board resets must not wipe what they record
  for (genvar b = 0; b < 8; b++) begin : g_flag
    always_ff @(posedge i_core_clk) begin
      if (!i_flags_por_n) begin
        flags[b] <= board_status_pkg::flags_reset[b];
      end else if (set_vec[b]) begin
        // set wins over a clear in the same cycle
        flags[b] <= 1'b1;
      end else if (clr_vec[b]) begin
        flags[b] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; led port is write only and answers nothing

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_io_rdata  <= 8'h00;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= rst_rd;
      o_io_rdata  <= rst_rd ? flags : 8'h00;
    end
  end

endmodule // board_led_and_reset_status

// ### sim/board_status_sva.sv
// assertions on the led and reset status block ports
`timescale 1ns/10ps
module board_status_sva (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic        i_evt_stby_power,
  input  wire logic        i_evt_main_power,
  input  wire logic        i_button_is_reset,
  input  wire logic        i_in_reset,
  input  wire logic        i_net_active,
  input  wire logic [7:0]  o_io_rdata,
  input  wire logic        o_io_rvalid,
  input  wire logic        o_led_red,
  input  wire logic        o_led_green,
  input  wire logic        o_led_blue
);
  wire lw = i_io_wr && (i_io_addr == 16'h0456);
  wire fw = i_io_wr && (i_io_addr == 16'h0457);
  wire fr = i_io_rd && (i_io_addr == 16'h0457);
  wire [2:0] rgb = {o_led_red, o_led_green, o_led_blue};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (fr |=> o_io_rvalid)
    else $error("no answer to flag read");
  chk_read_refused: assert property (!fr |=> !o_io_rvalid)
    else $error("answer without flag read");
  chk_rdata_idle: assert property (!o_io_rvalid |-> o_io_rdata == 8'h00)
    else $error("read data not idle");
  chk_led_manual: assert property (lw && i_io_wdata[3] ##1 !lw |=>
    rgb == $past(i_io_wdata[2:0], 2)) else $error("manual colour wrong");
  chk_auto_red: assert property (lw && i_io_wdata == 8'h00 && i_in_reset && !i_net_active
    ##1 !lw && i_in_reset && !i_net_active |=> rgb == 3'b100) else $error("auto red wrong");
  chk_clear_all: assert property (fw && i_io_wdata == 8'hff && !i_evt_stby_power
    ##1 !i_evt_stby_power ##1 fr |=> o_io_rdata[3] == 1'b0) else $error("flag not cleared");
  chk_stby_prio: assert property (i_evt_stby_power ##1 !fw ##1 fr |=>
    (o_io_rdata & 8'hfa) == 8'hfa) else $error("standby priority wrong");
  chk_main_prio: assert property (i_evt_main_power ##1 !fw ##1 fr |=>
    (o_io_rdata & 8'hf2) == 8'hf2) else $error("main priority wrong");
  chk_button_gate: assert property (fw && i_io_wdata[0] && !i_button_is_reset
    ##1 !i_button_is_reset [*3] ##1 fr |=> !o_io_rdata[0]) else $error("button bit set");
  cover property (fr ##1 o_io_rvalid);
  cover property (lw && i_io_wdata[3]);
  cover property (i_evt_stby_power ##2 fr);
endmodule // board_status_sva
bind board_led_and_reset_status board_status_sva chk (
  .i_core_clk        (i_core_clk),
  .i_reset_n         (i_reset_n),
  .i_io_addr         (i_io_addr),
  .i_io_wr           (i_io_wr),
  .i_io_rd           (i_io_rd),
  .i_io_wdata        (i_io_wdata),
  .i_evt_stby_power  (i_evt_stby_power),
  .i_evt_main_power  (i_evt_main_power),
  .i_button_is_reset (i_button_is_reset),
  .i_in_reset        (i_in_reset),
  .i_net_active      (i_net_active),
  .o_io_rdata        (o_io_rdata),
  .o_io_rvalid       (o_io_rvalid),
  .o_led_red         (o_led_red),
  .o_led_green       (o_led_green),
  .o_led_blue        (o_led_blue)
);

// ### sim/io_host.sv
// host model making byte i/o port cycles
`timescale 1ns/10ps
module io_host (
  input  wire logic        i_clk,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_rdata,
  output logic [15:0]      o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_wdata
);
  initial {o_addr, o_wr, o_rd, o_wdata} = 26'h0000000;
  // data idles inverted so a stale byte never looks like a fresh one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic v, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    // the answer stands one cycle only, so it is taken mid-cycle before it drops
    @(negedge i_clk);
    v = i_rvalid;
    d = i_rdata;
    o_rd = 1'b0;
  endtask
endmodule // io_host

// ### sim/board_led_and_reset_status_tb.sv
// self-checking bench for the led and reset status block
`timescale 1ns/10ps
module board_led_and_reset_status_tb;
  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, btn = 1'b1, wr, rd, rv, red, grn, blu, v;
  logic [7:0]  ev = 8'h00, wd, rdata, got;
  logic [6:0]  st = 7'h00;
  logic [15:0] addr;
  logic [7:0]  masks [8] = '{8'h01, 8'h02, 8'h04, 8'hfa, 8'h12, 8'h22, 8'h42, 8'hf2};
  logic [2:0]  autos [6] = '{3'b100, 3'b110, 3'b111, 3'b001, 3'b011, 3'b101};
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  always #2.5 clk = ~clk;
  io_host host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wd));
  board_led_and_reset_status dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_flags_por_n(por_n),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wd), .i_evt_main_power(ev[7]),
    .i_evt_core_power(ev[6]), .i_evt_nonstby_power(ev[5]), .i_evt_mem_power(ev[4]),
    .i_evt_stby_power(ev[3]), .i_evt_pci33(ev[2]), .i_evt_pci_reset(ev[1]),
    .i_evt_button(ev[0]), .i_button_is_reset(btn), .i_in_reset(st[0]), .i_standby(st[1]),
    .i_thermal_near(st[2]), .i_disk_active(st[3]), .i_link_10(st[4]), .i_link_100(st[5]),
    .i_net_active(st[6]), .o_io_rdata(rdata), .o_io_rvalid(rv), .o_led_red(red),
    .o_led_green(grn), .o_led_blue(blu));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic led(input logic [7:0] val, input logic [2:0] exp);
    host.wr(16'h0456, val);
    @(negedge clk);
    cmp("led", {5'h00, exp}, {5'h00, red, grn, blu});
  endtask
  task automatic rdf(input logic [15:0] a, input logic vexp, input logic [7:0] exp);
    host.rd(a, v, got);
    cmp("rvalid", {7'h00, vexp}, {7'h00, v});
    cmp("flags", exp, got);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 8'h00;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard; the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    @(negedge clk);
    rdf(16'h0457, 1'b1, 8'h00);
    cmp("auto", 8'h02, {5'h00, red, grn, blu});
    rdf(16'h0456, 1'b0, 8'h00);
    $display("test reset done");
    for (int i = 8; i < 16; i++) led(i[7:0], i[2:0]);
    led(8'h1c, 3'b100);
    for (int i = 0; i < 6; i++) begin
      st = 7'h01 << i;
      led(8'h00, autos[i]);
    end
    st = 7'h40;
    led(8'h00, 3'b010);
    st = 7'h00;
    $display("test led done");
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      rdf(16'h0457, 1'b1, masks[i]);
      host.wr(16'h0457, 8'hff);
      rdf(16'h0457, 1'b1, 8'h00);
    end
    pulse(8'h08);
    host.wr(16'h0457, 8'h0a);
    rdf(16'h0457, 1'b1, 8'hf0);
    // button gated off before the clear so the whole window is covered
    btn = 1'b0;
    host.wr(16'h0457, 8'hff);
    pulse(8'h01);
    rdf(16'h0457, 1'b1, 8'h00);
    led(8'h0f, 3'b111);
    pulse(8'h02);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdf(16'h0457, 1'b1, 8'h02);
    cmp("led after reset", 8'h02, {5'h00, red, grn, blu});
    $display("test flags done");
    wrap_up();
  end
endmodule // board_led_and_reset_status_tb
